/* hdl/acsrh_pkg.sv */
package acsrh_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 32;
	localparam int          RES_W          = 10;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CLK_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RES_HI  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RES_LO  = 8'h08;

	// clock config field layout and reset value
	localparam int          SEL_LSB        = 4;
	localparam int          SEL_MSB        = 6;
	localparam logic [2:0]  SEL_RST        = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// timing: system clock and dedicated rc oscillator limit
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          RC_MAX_KHZ     = 500;
	localparam int          RC_PERIOD_NS   = 1000000 / RC_MAX_KHZ;
	// least period rounds up to whole cycles
	localparam int          RC_CYC         = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// divider terminal counts (divide ratio minus one)
	localparam logic [5:0]  TC_DIV2        = 6'h01;
	localparam logic [5:0]  TC_DIV4        = 6'h03;
	localparam logic [5:0]  TC_DIV8        = 6'h07;
	localparam logic [5:0]  TC_DIV16       = 6'h0f;
	localparam logic [5:0]  TC_DIV32       = 6'h1f;
	localparam logic [5:0]  TC_DIV64       = 6'h3f;
	localparam logic [5:0]  TC_RC          = 6'(RC_CYC - 1);

endpackage : acsrh_pkg

/* hdl/acsrh_clk_div.sv */
`timescale 1ns/1ns
module acsrh_clk_div (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// selection from the clock config register
	input  wire logic [2:0] conv_clock_select_i,
	// one-cycle conversion clock enable
	output logic            conv_clk_en_o
);
	import acsrh_pkg::*;

	typedef struct packed {
		logic [5:0] cnt;
		logic       en;
	} acsrh_div_s;

	acsrh_div_s st_ff;
	acsrh_div_s nxt_st;
	logic [5:0] term;

	////////////////////////////////////////////////////////////////////////////////
	// divide ratio table
	always_comb begin
		unique case (conv_clock_select_i)
			3'h0: term = TC_DIV2;
			3'h4: term = TC_DIV4;
			3'h1: term = TC_DIV8;
			3'h5: term = TC_DIV16;
			3'h2: term = TC_DIV32;
			3'h6: term = TC_DIV64;
			3'h3: term = TC_RC;
			3'h7: term = TC_RC;
		endcase
	end

	// compare with >= so a shrinking ratio never strands the counter
	always_comb begin
		nxt_st = st_ff;
		if (sys_rst_i) begin
			nxt_st.cnt = 6'h00;
			nxt_st.en  = 1'b0;
		end else if (st_ff.cnt >= term) begin
			nxt_st.cnt = 6'h00;
			nxt_st.en  = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 6'h01;
			nxt_st.en  = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	assign conv_clk_en_o = st_ff.en;

endmodule : acsrh_clk_div

/* hdl/acsrh_res_fmt.sv */
`timescale 1ns/1ns
module acsrh_res_fmt (
	// raw conversion result and format
	input  wire logic [9:0] conv_result_bits_i,
	input  wire logic       result_format_select_i,
	// formatted register images
	output logic [7:0]      res_hi_o,
	output logic [7:0]      res_lo_o
);
	////////////////////////////////////////////////////////////////////////////////
	// justify the ten bits into two byte images; unused bits fill with zero
	always_comb begin
		if (result_format_select_i) begin
			res_hi_o = {6'h00, conv_result_bits_i[9:8]};
			res_lo_o = conv_result_bits_i[7:0];
		end else begin
			res_hi_o = conv_result_bits_i[9:2];
			res_lo_o = {conv_result_bits_i[1:0], 6'h00};
		end
	end

endmodule : acsrh_res_fmt

/* hdl/acsrh_top.sv */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - select code picks system clock divide by 2,4,8,16,32 or 64
// - codes with both low bits set use the dedicated rc oscillator rate
// - clock config bit 7 and bits 3..0 ignore writes, read zero
// - left justified: result bits 9..2 land in high register bits 7..0
// - ten bit result split across high and low result registers
// - left justified: result bits 1..0 in low register bits 7..6
// - right justified: bits 9..8 in high 1..0, bits 7..0 in low
module acsrh_top (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         sys_rst_i,
	// axi4-lite write address
	input  wire logic [acsrh_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                         s_axi_awvalid_i,
	output logic                              s_axi_awready_o,
	// axi4-lite write data
	input  wire logic [acsrh_pkg::DATA_W-1:0] s_axi_wdata_i,
	input  wire logic [3:0]                   s_axi_wstrb_i,
	input  wire logic                         s_axi_wvalid_i,
	output logic                              s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0]                        s_axi_bresp_o,
	output logic                              s_axi_bvalid_o,
	input  wire logic                         s_axi_bready_i,
	// axi4-lite read address
	input  wire logic [acsrh_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                         s_axi_arvalid_i,
	output logic                              s_axi_arready_o,
	// axi4-lite read data
	output logic [acsrh_pkg::DATA_W-1:0]      s_axi_rdata_o,
	output logic [1:0]                        s_axi_rresp_o,
	output logic                              s_axi_rvalid_o,
	input  wire logic                         s_axi_rready_i,
	// converter core side
	input  wire logic                         conv_done_i,
	input  wire logic [acsrh_pkg::RES_W-1:0]  conv_result_bits_i,
	input  wire logic                         result_format_select_i,
	output logic                              conv_clk_en_o
);
	import acsrh_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// whole block state in one record
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic [2:0]        clk_sel;
		logic [7:0]        res_hi;
		logic [7:0]        res_lo;
	} acsrh_regs_s;

	acsrh_regs_s st_ff;
	acsrh_regs_s nxt_st;
	logic [7:0]  fmt_hi;
	logic [7:0]  fmt_lo;
	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic        wr_go;

	////////////////////////////////////////////////////////////////////////////////
	// conversion clock divider
	acsrh_clk_div acsrh_clk_div_inst (
		.clk_i               (clk_i),
		.sys_rst_i           (sys_rst_i),
		.conv_clock_select_i (st_ff.clk_sel),
		.conv_clk_en_o       (conv_clk_en_o)
	);

	acsrh_res_fmt acsrh_res_fmt_inst (
		.conv_result_bits_i     (conv_result_bits_i),
		.result_format_select_i (result_format_select_i),
		.res_hi_o               (fmt_hi),
		.res_lo_o               (fmt_lo)
	);

	////////////////////////////////////////////////////////////////////////////////
	// channel handshakes
	assign aw_hs = st_ff.awready & s_axi_awvalid_i;
	assign w_hs  = st_ff.wready & s_axi_wvalid_i;
	assign ar_hs = st_ff.arready & s_axi_arvalid_i;
	// write commits once both halves are held and no response is pending
	assign wr_go = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;

	// read decode, unmapped answers slverr with zero data
	function automatic logic [DATA_W+1:0] rd_decode(input logic [ADDR_W-1:0] a,
		input acsrh_regs_s s);
		logic [DATA_W+1:0] r;
		r = {RESP_SLVERR, {DATA_W{1'b0}}};
		unique case ({a[ADDR_W-1:2], 2'h0})
			OFS_CLK_CFG: r = {RESP_OKAY, 24'h000000, 1'b0, s.clk_sel, 4'h0};
			OFS_RES_HI:  r = {RESP_OKAY, 24'h000000, s.res_hi};
			OFS_RES_LO:  r = {RESP_OKAY, 24'h000000, s.res_lo};
			default:     r = {RESP_SLVERR, {DATA_W{1'b0}}};
		endcase
		return r;
	endfunction : rd_decode

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		nxt_st = st_ff;
		// write address and data are captured independently, in any order
		if (aw_hs) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr_i;
		end
		if (w_hs) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata_i;
			nxt_st.wstrb = s_axi_wstrb_i;
		end
		if (wr_go) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = RESP_OKAY;
			unique case ({st_ff.awaddr[ADDR_W-1:2], 2'h0})
				OFS_CLK_CFG: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.clk_sel = st_ff.wdata[SEL_MSB:SEL_LSB];
					end
				end
				OFS_RES_HI: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.res_hi = st_ff.wdata[7:0];
					end
				end
				OFS_RES_LO: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.res_lo = st_ff.wdata[7:0];
					end
				end
				default: begin
					nxt_st.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (st_ff.bvalid && s_axi_bready_i) begin
			nxt_st.bvalid = 1'b0;
		end
		// conversion overwrites result
		// hardware update wins over a software write in the same cycle
		if (conv_done_i) begin
			nxt_st.res_hi = fmt_hi;
			nxt_st.res_lo = fmt_lo;
		end
		// read answers on the edge after the address is taken
		if (ar_hs) begin
			nxt_st.rvalid = 1'b1;
			{nxt_st.rresp, nxt_st.rdata} = rd_decode(s_axi_araddr_i, st_ff);
		end else if (st_ff.rvalid && s_axi_rready_i) begin
			nxt_st.rvalid = 1'b0;
		end
		// one transaction of each kind at a time
		nxt_st.awready = ~nxt_st.aw_got & ~nxt_st.bvalid;
		nxt_st.wready  = ~nxt_st.w_got & ~nxt_st.bvalid;
		nxt_st.arready = ~nxt_st.rvalid;
		// results keep their value over reset
		if (sys_rst_i) begin
			nxt_st.awready = 1'b0;
			nxt_st.wready  = 1'b0;
			nxt_st.aw_got  = 1'b0;
			nxt_st.w_got   = 1'b0;
			nxt_st.awaddr  = '0;
			nxt_st.wdata   = '0;
			nxt_st.wstrb   = 4'h0;
			nxt_st.bvalid  = 1'b0;
			nxt_st.bresp   = RESP_OKAY;
			nxt_st.arready = 1'b0;
			nxt_st.rvalid  = 1'b0;
			nxt_st.rdata   = '0;
			nxt_st.rresp   = RESP_OKAY;
			nxt_st.clk_sel = SEL_RST;
			nxt_st.res_hi  = st_ff.res_hi;
			nxt_st.res_lo  = st_ff.res_lo;
		end
	end

	// single state register
	always_ff @(posedge clk_i) begin
		st_ff <= nxt_st;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign s_axi_awready_o = st_ff.awready;
	assign s_axi_wready_o  = st_ff.wready;
	assign s_axi_bresp_o   = st_ff.bresp;
	assign s_axi_bvalid_o  = st_ff.bvalid;
	assign s_axi_arready_o = st_ff.arready;
	assign s_axi_rdata_o   = st_ff.rdata;
	assign s_axi_rresp_o   = st_ff.rresp;
	assign s_axi_rvalid_o  = st_ff.rvalid;

endmodule : acsrh_top

/* verif/acsrh_checker.sv */
`timescale 1ns/1ns
module acsrh_checker (
	// clock and reset
	input wire logic                         clk_i,
	input wire logic                         sys_rst_i,
	// bus handshakes
	input wire logic                         s_axi_awvalid_i,
	input wire logic                         s_axi_awready_o,
	input wire logic                         s_axi_wvalid_i,
	input wire logic                         s_axi_wready_o,
	input wire logic [1:0]                   s_axi_bresp_o,
	input wire logic                         s_axi_bvalid_o,
	input wire logic                         s_axi_bready_i,
	input wire logic [acsrh_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic                         s_axi_arvalid_i,
	input wire logic                         s_axi_arready_o,
	input wire logic [acsrh_pkg::DATA_W-1:0] s_axi_rdata_o,
	input wire logic                         s_axi_rvalid_o,
	input wire logic                         s_axi_rready_i,
	// converter side
	input wire logic                         conv_clk_en_o
);
	import acsrh_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [7:0] rd_addr_ff;
	logic [6:0] gap_ff;
	// read address capture and cycles since the last rate pulse
	always_ff @(posedge clk_i) begin
		if (s_axi_arvalid_i && s_axi_arready_o)
			rd_addr_ff <= s_axi_araddr_i;
		gap_ff <= (sys_rst_i || conv_clk_en_o) ? 7'h00 : gap_ff + 7'h01;
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_en_pulse; conv_clk_en_o |=> !conv_clk_en_o; endproperty
	a_en_pulse: assert property (p_en_pulse) else $error("rate pulse too long");
	// slowest rate is divide by 64, so no longer gap is legal
	property p_en_gap; gap_ff <= 7'h40; endproperty
	a_en_gap: assert property (p_en_gap) else $error("rate pulse gap too long");
	property p_rd_lat; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_rd_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	property p_rd_upper; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
	property p_cfg_zero;
		s_axi_rvalid_o && rd_addr_ff == OFS_CLK_CFG |-> !s_axi_rdata_o[7] && s_axi_rdata_o[3:0] == 4'h0;
	endproperty
	a_cfg_zero: assert property (p_cfg_zero) else $error("config spare bits set");
	property p_wr_resp;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_b_hold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
endmodule : acsrh_checker

/* verif/acsrh_top_test.sv */
`timescale 1ns/1ns
module acsrh_top_test;
	import acsrh_pkg::*;
	logic       clk_i, sys_rst_i, awv, wv, bry, arv, rry, done, fmt;
	logic       awr, wr, bv, arr, rv, en;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, d;
	logic [3:0] ws;
	logic [1:0] br, rr, r;
	logic [9:0] res;
	logic [15:0] e;
	int         error_cnt, checked, seed, n, c, i;
	acsrh_top acsrh_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
		.conv_done_i(done), .conv_result_bits_i(res), .result_format_select_i(fmt),
		.conv_clk_en_o(en));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	// one bus transfer; held until each channel's own ready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s);
		logic ap, dp, fin;
		int k;
		ap = 1'b1;
		dp = w;
		fin = 1'b0;
		k = 0;
		@(posedge clk_i);
		if (w) begin
			awa <= a; wd <= v; ws <= s; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
		end else begin
			ara <= a; arv <= 1'b1; rry <= 1'b1;
		end
		while (!fin && k < 100) begin
			@(posedge clk_i);
			k++;
			if (ap && (w ? awr : arr) === 1'b1) begin
				ap = 1'b0; awv <= 1'b0; arv <= 1'b0;
			end
			if (dp && wr === 1'b1) begin
				dp = 1'b0; wv <= 1'b0;
			end
			if ((w ? bv : rv) === 1'b1) begin
				fin = 1'b1; r = w ? br : rr; d = rd; bry <= 1'b0; rry <= 1'b0;
			end
		end
		if (!fin) chk(32'h0, 32'h1);
	endtask : xfer
	// cycles to the next rate pulse
	task automatic wt();
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (en !== 1'b1 && n < 300);
	endtask : wt
	function automatic int div(input int k);
		case (k)
			0: return 2; 4: return 4; 1: return 8; 5: return 16; 2: return 32; 6: return 64;
			default: return RC_CYC;
		endcase
	endfunction : div
	// high and low register images of one result, per justification
	function automatic logic [15:0] img(input logic f, input logic [9:0] v);
		return f ? {6'h00, v[9:8], v[7:0]} : {v[9:2], v[1:0], 6'h00};
	endfunction : img
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// watchdog, well beyond the expected run of under a thousand cycles
	initial begin
		#3000000;
		error_cnt++;
		results();
	end
	initial begin
		{awv, wv, bry, arv, rry, done, fmt, awa, ara, wd, ws, res} = '0;
		sys_rst_i = 1'b1;
		error_cnt = 0;
		checked = 0;
		seed = 32'h95d81196;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		xfer(0, OFS_CLK_CFG, 0, 0); chk(d, 32'h0);
		// unmapped read: error response with zero data
		xfer(0, 8'h0c, 0, 0);
		chk(32'(r), 32'(RESP_SLVERR));
		chk(d, 32'h0);
		// every select code, spare bits written as ones
		for (c = 0; c < 8; c++) begin
			xfer(1, OFS_CLK_CFG, 32'hffffff8f | (c << 4), 4'hf);
			xfer(0, OFS_CLK_CFG, 0, 0); chk(d, c << 4);
			wt(); wt(); wt(); chk(n, div(c));
		end
		xfer(1, OFS_RES_HI, 32'ha5, 4'hf); chk(32'(r), 32'(RESP_OKAY));
		xfer(0, OFS_RES_HI, 0, 0); chk(d, 32'ha5);
		// low byte lane disabled: nothing stored
		xfer(1, OFS_RES_HI, 32'h5a, 4'he);
		xfer(0, OFS_RES_HI, 0, 0); chk(d, 32'ha5);
		// conversions overwrite, both formats, all ones first
		for (i = 0; i < 12; i++) begin
			@(posedge clk_i);
			res <= (i < 2) ? 10'h3ff : 10'($random(seed));
			fmt <= (i < 2) ? i[0] : 1'($random(seed));
			done <= 1'b1;
			@(posedge clk_i);
			done <= 1'b0;
			e = img(fmt, res);
			xfer(0, OFS_RES_HI, 0, 0); chk(d, 32'(e[15:8]));
			xfer(0, OFS_RES_LO, 0, 0); chk(d, 32'(e[7:0]));
		end
		// unmapped write answers an error and leaves the select alone
		xfer(1, 8'h0c, 32'hffffffff, 4'hf);
		chk(32'(r), 32'(RESP_SLVERR));
		xfer(0, OFS_CLK_CFG, 0, 0); chk(d, 7 << SEL_LSB);
		// reset in mid-run: select back to 000, result high kept
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		xfer(0, OFS_CLK_CFG, 0, 0); chk(d, 32'h0);
		xfer(0, OFS_RES_HI, 0, 0); chk(d, 32'(e[15:8]));
		wt(); wt(); chk(n, div(0));
		results();
	end
endmodule : acsrh_top_test
bind acsrh_top acsrh_checker acsrh_checker_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .conv_clk_en_o(conv_clk_en_o));
